// ===== rtl/aod_regs.vh
// constants of the converter output demux and control block
// assumes inclusion by bare name from the design files under rtl/
`ifndef AOD_REGS_VH
`define AOD_REGS_VH

// apb register byte offsets
`define AOD_CTRL_OFS     12'h000
`define AOD_STAT_OFS     12'h004

// control register fields
`define AOD_CTRL_DDR     0
`define AOD_CTRL_RST     32'h0000_0000

// status register fields
`define AOD_STAT_TUNE    0
`define AOD_STAT_SLEEP   1
`define AOD_STAT_EDGE    2
`define AOD_STAT_DRV     3
`define AOD_STAT_PORW    4

// on-command trigger qualification, in sample clock cycles
`define AOD_CAL_LOW_CYC  24'h00_0050
`define AOD_CAL_HIGH_CYC 24'h00_0050

// power-on delay and selftune length, in sample clock cycles
`define AOD_POR_DELAY    24'h00_2000
`define AOD_CAL_LEN      24'h00_8000

// state codes of the control sequencer
`define AOD_ST_PORW      2'h0
`define AOD_ST_RUN       2'h1
`define AOD_ST_TUNE      2'h2
`define AOD_ST_SLEEP     2'h3

`endif

// ===== rtl/aod_top.v
// output demux, forwarded clock and control pin logic of an 8-bit
// converter; assumes clk_sys is the sample clock, one result per cycle
// on sample_in from same-clock logic, pins from outside the domain.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`include "aod_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module aod_top #(
  parameter [23:0] POR_DELAY_CYC = `AOD_POR_DELAY, // power-on wait
  parameter [23:0] CAL_LEN_CYC   = `AOD_CAL_LEN    // selftune length
) (
  input  wire        clk_sys,             // sample clock, 100 MHz
  input  wire        srst,                // sync reset, active high
  input  wire [7:0]  sample_in,           // two's complement result
  input  wire        data_edge_select,    // pin: fclk edge for data
  input  wire        driver_level_select, // pin: output drive level
  input  wire        sleep_request,       // pin: power-down request
  input  wire        selftune_request,    // pin: manual selftune
  input  wire [11:0] paddr,               // apb address
  input  wire        psel,                // apb select
  input  wire        penable,             // apb enable
  input  wire        pwrite,              // apb direction
  input  wire [31:0] pwdata,              // apb write data
  output reg  [31:0] prdata,              // apb read data
  output wire        pready,              // apb ready
  output reg         pslverr,             // apb error
  output reg  [7:0]  bus_a_q,             // odd conversions
  output reg  [7:0]  bus_b_q,             // even conversions
  output reg         data_oe,             // data pins driven
  output reg         forwarded_data_clock,   // fclk true leg
  output reg         forwarded_data_clock_n, // fclk complement leg
  output reg         fclk_oe,             // fclk pins driven
  output reg         driver_strong,       // strong driver enable
  output reg         selftune_active,     // selftune running
  output reg         analog_off           // analog held powered down
);

  // result coding: flip the sign bit of two's complement
  function [7:0] to_offset;
    input [7:0] v;
    begin
      to_offset = {~v[7], v[6:0]};
    end
  endfunction

  // saturating increment used by every counter here
  function [23:0] sat_inc;
    input [23:0] v;
    begin
      sat_inc = (v == 24'hFF_FFFF) ? v : v + 24'h00_0001;
    end
  endfunction

  // two-flop synchronisers for the four pins
  reg  [3:0] pin_s1_reg;
  reg  [3:0] pin_s2_reg;
  wire       edge_sel;
  wire       lvl_sel;
  wire       sleep_in;
  wire       tune_pin;

  always @(posedge clk_sys) begin
    if (srst) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
    end else begin
      pin_s1_reg <= {selftune_request, sleep_request,
                     driver_level_select, data_edge_select};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign edge_sel = pin_s2_reg[0];
  assign lvl_sel  = pin_s2_reg[1];
  assign sleep_in = pin_s2_reg[2];
  assign tune_pin = pin_s2_reg[3];

  // apb registers
  reg ddr_mode_reg;

  // state and counters
  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [23:0] cnt_reg;
  reg [23:0] cnt_next;
  reg [23:0] lo_cnt_reg;
  reg [23:0] hi_cnt_reg;
  reg        armed_reg;
  reg        tune_trig;

  // manual request qualification: long low, then long high
  always @(posedge clk_sys) begin
    if (srst) begin
      lo_cnt_reg <= 24'h00_0000;
      hi_cnt_reg <= 24'h00_0000;
      armed_reg  <= 1'b0;
    end else if (state_reg == `AOD_ST_SLEEP ||
                 (state_reg == `AOD_ST_PORW && sleep_in)) begin
      // requests made while asleep are thrown away whole
      lo_cnt_reg <= 24'h00_0000;
      hi_cnt_reg <= 24'h00_0000;
      armed_reg  <= 1'b0;
    end else if (!tune_pin) begin
      hi_cnt_reg <= 24'h00_0000;
      lo_cnt_reg <= sat_inc(lo_cnt_reg);
      if (lo_cnt_reg >= `AOD_CAL_LOW_CYC - 24'h00_0001) begin
        armed_reg <= 1'b1;
      end
    end else begin
      lo_cnt_reg <= 24'h00_0000;
      if (armed_reg) begin
        hi_cnt_reg <= sat_inc(hi_cnt_reg);
      end
      if (tune_trig) begin
        armed_reg  <= 1'b0;
        hi_cnt_reg <= 24'h00_0000;
      end
    end
  end

  // trigger once the high phase has lasted long enough
  always @* begin
    tune_trig = armed_reg && tune_pin &&
                (hi_cnt_reg >= `AOD_CAL_HIGH_CYC - 24'h00_0001) &&
                (state_reg != `AOD_ST_SLEEP);
  end

  // control sequencer; reset lands in the power-on wait, so the
  // analog side stays off until the clock has run the wait out
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      `AOD_ST_PORW: begin
        // delay counter frozen while sleep is requested
        if (!sleep_in) begin
          cnt_next = sat_inc(cnt_reg);
          if (cnt_reg >= POR_DELAY_CYC - 24'h00_0001) begin
            cnt_next = 24'h00_0000;
            // pin high at power-up skips the power-on selftune
            if (tune_pin) begin
              state_next = `AOD_ST_RUN;
            end else begin
              state_next = `AOD_ST_TUNE;
            end
          end
        end
      end
      `AOD_ST_RUN: begin
        cnt_next = 24'h00_0000;
        if (sleep_in) begin
          state_next = `AOD_ST_SLEEP;
        end else if (tune_trig) begin
          state_next = `AOD_ST_TUNE;
        end
      end
      `AOD_ST_TUNE: begin
        // sleep is only looked at once the run is over
        cnt_next = sat_inc(cnt_reg);
        if (cnt_reg >= CAL_LEN_CYC - 24'h00_0001) begin
          cnt_next = 24'h00_0000;
          if (sleep_in) begin
            state_next = `AOD_ST_SLEEP;
          end else begin
            state_next = `AOD_ST_RUN;
          end
        end
      end
      default: begin
        cnt_next = 24'h00_0000;
        if (!sleep_in) begin
          state_next = `AOD_ST_RUN;
        end
      end
    endcase
  end

  // sequencer registers
  always @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= `AOD_ST_PORW;
      cnt_reg   <= 24'h00_0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // demux: phase 0 is an odd conversion, phase 1 an even one
  reg       phase_reg;
  reg [7:0] odd_word_reg;
  reg [7:0] pair_a_reg;
  reg [7:0] pair_b_reg;
  wire      converting;

  assign converting = (state_reg == `AOD_ST_RUN);

  always @(posedge clk_sys) begin
    if (srst) begin
      phase_reg    <= 1'b0;
      odd_word_reg <= 8'h00;
      pair_a_reg   <= 8'h00;
      pair_b_reg   <= 8'h00;
    end else if (converting) begin
      phase_reg <= ~phase_reg;
      if (!phase_reg) begin
        odd_word_reg <= to_offset(sample_in);
      end else begin
        pair_a_reg <= odd_word_reg;
        pair_b_reg <= to_offset(sample_in);
      end
    end else begin
      // restart pairing cleanly after any pause
      phase_reg <= 1'b0;
    end
  end

  // forwarded clock: sdr toggles each cycle, ddr every second cycle
  reg  fclk_next;
  reg  upd;

  always @* begin
    fclk_next = 1'b0;
    // park the clock on the very edge that leaves run, so it is
    // already low in the first cycle that selftune_active shows
    if (converting && state_next == `AOD_ST_RUN) begin
      if (ddr_mode_reg) begin
        fclk_next = phase_reg ? ~forwarded_data_clock
                              : forwarded_data_clock;
      end else begin
        fclk_next = ~forwarded_data_clock;
      end
    end
    // sdr moves data on the selected edge only, ddr on both
    upd = converting && (state_next == `AOD_ST_RUN) &&
          (fclk_next != forwarded_data_clock) &&
          (ddr_mode_reg || (fclk_next == edge_sel));
  end

  // output pins; one fclk pair clocks both buses
  always @(posedge clk_sys) begin
    if (srst) begin
      forwarded_data_clock   <= 1'b0;
      forwarded_data_clock_n <= 1'b1;
      bus_a_q                <= 8'h00;
      bus_b_q                <= 8'h00;
      data_oe                <= 1'b0;
      fclk_oe                <= 1'b0;
    end else begin
      // clock parked low through selftune and sleep
      forwarded_data_clock   <= fclk_next;
      forwarded_data_clock_n <= ~fclk_next;
      if (upd) begin
        bus_a_q <= pair_a_reg;
        bus_b_q <= pair_b_reg;
      end
      // a sleep request in the power-on wait also releases the pins
      data_oe <= !((state_next == `AOD_ST_SLEEP) ||
                   (state_next == `AOD_ST_PORW && sleep_in));
      fclk_oe <= !((state_next == `AOD_ST_SLEEP) ||
                   (state_next == `AOD_ST_PORW && sleep_in));
    end
  end

  // status style outputs
  always @(posedge clk_sys) begin
    if (srst) begin
      selftune_active <= 1'b0;
      driver_strong   <= 1'b0;
      analog_off      <= 1'b1;
    end else begin
      selftune_active <= (state_next == `AOD_ST_TUNE);
      driver_strong   <= lvl_sel;
      analog_off      <= (state_next == `AOD_ST_SLEEP) ||
                         (state_next == `AOD_ST_PORW);
    end
  end

  // apb slave: zero wait states, error on unmapped addresses
  wire        setup_ph;
  wire        wr_acc;
  wire [31:0] stat_word;

  assign pready    = 1'b1;
  assign setup_ph  = psel && !penable;
  assign wr_acc    = psel && penable && pwrite;
  assign stat_word = {27'h000_0000,
                      state_reg == `AOD_ST_PORW,
                      driver_strong,
                      edge_sel,
                      state_reg == `AOD_ST_SLEEP,
                      selftune_active};

  // control register write; the mode steers the divider above
  always @(posedge clk_sys) begin
    if (srst) begin
      ddr_mode_reg <= |(`AOD_CTRL_RST & 32'h0000_0001);
    end else if (wr_acc && paddr == `AOD_CTRL_OFS) begin
      ddr_mode_reg <= pwdata[`AOD_CTRL_DDR];
    end
  end

  // read data and error latched in setup so they are stable in access
  always @(posedge clk_sys) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      if (paddr == `AOD_CTRL_OFS) begin
        prdata  <= {31'h0000_0000, ddr_mode_reg};
        pslverr <= 1'b0;
      end else if (paddr == `AOD_STAT_OFS) begin
        prdata  <= pwrite ? 32'h0000_0000 : stat_word;
        pslverr <= 1'b0;
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b1;
      end
    end
  end

endmodule // aod_top

`default_nettype wire

// ===== verif/aod_properties.sv
// checker: port properties of the converter output block
// assumes one clock domain; bound to aod_top at the foot
`timescale 1ns/1ps
`default_nettype none
module aod_props #(
  parameter [23:0] POR_DELAY_CYC = 24'h00_0010, // power-on wait
  parameter [23:0] CAL_LEN_CYC   = 24'h00_0020  // tune length
) (
  input wire logic        clk_sys,              // clock
  input wire logic        srst,                 // reset
  input wire logic        data_edge_select,     // pin
  input wire logic        driver_level_select,  // pin
  input wire logic        sleep_request,        // pin
  input wire logic [11:0] paddr,                // apb
  input wire logic        psel,                 // apb
  input wire logic        penable,              // apb
  input wire logic        pwrite,               // apb
  input wire logic [31:0] pwdata,               // apb
  input wire logic [7:0]  bus_a_q,              // odd words
  input wire logic [7:0]  bus_b_q,              // even words
  input wire logic        data_oe,              // data driven
  input wire logic        forwarded_data_clock, // fclk true leg
  input wire logic        forwarded_data_clock_n, // fclk complement
  input wire logic        fclk_oe,              // fclk driven
  input wire logic        driver_strong,        // drive level
  input wire logic        selftune_active,      // tuning
  input wire logic        analog_off            // analog down
);
  logic        ddr_q;
  logic [7:0]  dh, lv;
  logic [3:0]  es;
  logic [23:0] tcnt;
  wire live = data_oe & !selftune_active & !analog_off;
  wire fc   = forwarded_data_clock;
  wire sdr  = live & (&lv) & !ddr_q & (dh == 8'h00);
  wire ddr  = live & (&lv) & ddr_q & (&dh);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // histories: a fresh mode, pin level or wake-up never counts as steady
  always @(posedge clk_sys) begin
    if (srst)
      ddr_q <= 1'b0;
    else if (psel && penable && pwrite && paddr == 12'h000)
      ddr_q <= pwdata[0];
    dh   <= {dh[6:0], ddr_q};
    es   <= {es[2:0], data_edge_select};
    lv   <= {lv[6:0], live & !srst};
    tcnt <= selftune_active ? tcnt + 24'h00_0001 : 24'h00_0000;
  end
  property p_rise;
    sdr && es == 4'hf && $changed(bus_a_q) |-> $rose(fc);
  endproperty
  a_rise: assert property (p_rise) else $error("data off rise");
  property p_fall;
    sdr && es == 4'h0 && $changed(bus_a_q) |-> $fell(fc);
  endproperty
  a_fall: assert property (p_fall) else $error("data off fall");
  property p_sdr; sdr |-> fc != $past(fc); endproperty
  a_sdr: assert property (p_sdr) else $error("sdr rate");
  property p_ddr;
    ddr |-> fc != $past(fc, 2) && (!$changed(bus_b_q) || $changed(fc));
  endproperty
  a_ddr: assert property (p_ddr) else $error("ddr rate");
  property p_len;
    $fell(selftune_active) && !$past(srst) |-> tcnt == CAL_LEN_CYC;
  endproperty
  a_len: assert property (p_len) else $error("tune length");
  property p_sleep;
    (sleep_request && !selftune_active) [*6] |->
      !data_oe && !fclk_oe && analog_off;
  endproperty
  a_sleep: assert property (p_sleep) else $error("driven asleep");
  property p_legs; forwarded_data_clock_n == !fc; endproperty
  a_legs: assert property (p_legs) else $error("clock legs");
  property p_awake; selftune_active |-> !analog_off && !fc; endproperty
  a_awake: assert property (p_awake) else $error("tune state");
  property p_drv;
    $stable(driver_level_select) [*5] |-> driver_strong == driver_level_select;
  endproperty
  a_drv: assert property (p_drv) else $error("drive level");
endmodule // aod_props
bind aod_top aod_props #(.POR_DELAY_CYC(POR_DELAY_CYC),
  .CAL_LEN_CYC(CAL_LEN_CYC)) prop_u (.clk_sys, .srst, .data_edge_select,
  .driver_level_select, .sleep_request, .paddr, .psel, .penable, .pwrite,
  .pwdata, .bus_a_q, .bus_b_q, .data_oe, .forwarded_data_clock,
  .forwarded_data_clock_n, .fclk_oe,
  .driver_strong, .selftune_active, .analog_off);
`default_nettype wire

// ===== verif/aod_rx.sv
// receiver model: captures both buses with the forwarded clock
// assumes it samples the pins as wired, on the sample clock
`timescale 1ns/1ps
`default_nettype none
module aod_rx (
  input  wire logic       clk_sys, // receiver clock
  input  wire logic       fclk,    // forwarded clock wire
  input  wire logic [7:0] a_in,    // bus a wire
  input  wire logic [7:0] b_in,    // bus b wire
  input  wire logic       live,    // pins driven, no tune
  input  wire logic       edge_hi, // launch on rise
  input  wire logic       ddr,     // launch on both edges
  output logic            got,     // pair captured
  output logic [7:0]      wa,      // bus a word
  output logic [7:0]      wb       // bus b word
);
  logic       fp;
  logic [1:0] skip;
  // launch edge seen one sample late, so the new word has settled
  always @(posedge clk_sys) begin
    fp  <= fclk;
    got <= 1'b0;
    if (!live)
      skip <= 2'h2;
    else if (fclk != fp && (ddr || fclk == edge_hi)) begin
      if (skip != 2'h0)
        skip <= skip - 2'h1;
      else begin
        got <= 1'b1;
        wa  <= a_in;
        wb  <= b_in;
      end
    end
  end
endmodule // aod_rx
`default_nettype wire

// ===== verif/testbench.sv
// testbench: random samples, pin and apb sequences, pair checks
// assumes aod_top with shortened power-on and selftune counts
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_sys, srst, psel, penable, pwrite, ddr, er;
  logic        data_edge_select, driver_level_select;
  logic        sleep_request, selftune_request;
  logic [7:0]  sample_in, s, cy, hist [0:255];
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire  [7:0]  bus_a_q, bus_b_q, wa, wb;
  wire         pready, pslverr, data_oe, fc, fclk_oe, tune, got;
  integer      seed = 32'h786b;
  int          bad_count = 0, checks_done = 0, tc = 0, ncap = 0;
  aod_top #(.POR_DELAY_CYC(24'h00_0010), .CAL_LEN_CYC(24'h00_0020)) dut_u (
    .clk_sys, .srst, .sample_in, .data_edge_select, .driver_level_select,
    .sleep_request, .selftune_request, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .bus_a_q, .bus_b_q, .data_oe,
    .forwarded_data_clock(fc), .forwarded_data_clock_n(), .fclk_oe,
    .driver_strong(), .selftune_active(tune), .analog_off());
  // released pins show the inverse of their last level
  aod_rx rx_u (.clk_sys, .fclk(fclk_oe ? fc : !fc), .ddr, .got, .wa, .wb,
    .a_in(data_oe ? bus_a_q : ~bus_a_q), .b_in(data_oe ? bus_b_q : ~bus_b_q),
    .live(data_oe & !tune), .edge_hi(data_edge_select));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task give_verdict;
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one apb transfer; answer taken at the edge where pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge clk_sys);
  endtask
  task caps(input int n);
    int m;
    m = ncap + n;
    driver_level_select <= 1'($random(seed));
    while (ncap < m) @(posedge clk_sys);
  endtask
  // pair must be two adjacent recent samples, msb flipped
  function automatic logic pair_ok(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] j;
    pair_ok = 1'b0;
    for (int k = 2; k < 48; k++) begin
      j = cy - 8'(k);
      if ({hist[j], hist[j + 8'h01]} === ({a, b} ^ 16'h8080))
        pair_ok = 1'b1;
    end
  endfunction
  // random words with full-scale corners every eighth cycle
  always @(posedge clk_sys) begin
    s = cy[2:0] == 3'h0 ? {cy[3], {7{~cy[3]}}} : 8'($random(seed));
    sample_in <= s;
    hist[cy] <= s;
    cy <= cy + 8'h01;
    if (tune === 1'b1) tc <= tc + 1;
    if (got === 1'b1) begin
      ncap <= ncap + 1;
      chk(32'(pair_ok(wa, wb)), 1);
    end
  end
  initial begin
    {srst, psel, penable, pwrite, ddr, cy} = {5'h10, 8'h00};
    {paddr, pwdata, sample_in} = {12'h000, 32'h0, 8'h00};
    {data_edge_select, driver_level_select} = 2'b11;
    {sleep_request, selftune_request} = 2'b10;
    tick(12);
    srst <= 1'b0;
    // asleep from power-up, with a well formed manual request
    tick(90);
    selftune_request <= 1'b1;
    tick(90);
    selftune_request <= 1'b0;
    tick(20);
    chk(tc, 0);
    sleep_request <= 1'b0;
    tick(80);
    chk(tc, 32);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h0000_001f, 32'h0000_000c);
    apb(1'b0, 12'h008, 32'h0);
    chk(32'(er), 1);
    apb(1'b1, 12'h004, 32'hffff_ffff);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h0000_0013, 0);
    caps(30);
    data_edge_select <= 1'b0;
    caps(30);
    apb(1'b1, 12'h000, 32'h1);
    ddr <= 1'b1;
    caps(30);
    // sleep raised mid-tune waits for the tune to end
    selftune_request <= 1'b1;
    while (tune !== 1'b1) @(posedge clk_sys);
    sleep_request <= 1'b1;
    tick(10);
    chk(32'(tune), 1);
    while (tune === 1'b1) @(posedge clk_sys);
    tick(8);
    chk(32'(data_oe), 0);
    chk(32'(fclk_oe), 0);
    {selftune_request, sleep_request} <= 2'b00;
    caps(20);
    give_verdict;
  end
  // watchdog well past the expected run length
  initial begin
    #100000;
    bad_count++;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
